// File: verilog/bdirq_defs.svh
// Offsets, field positions, reset values and jumper defaults of the done/request block.
// Assumes a word-wide register port with byte offsets.
`ifndef BDIRQ_DEFS_SVH
`define BDIRQ_DEFS_SVH
// ==========================================================
// Register offsets
`define BDIRQ_TXCSR   8'h00
`define BDIRQ_RXCSR   8'h04
`define BDIRQ_ERRCSR  8'h08
// ==========================================================
// Control/status field positions
`define BDIRQ_RUN     0
`define BDIRQ_DONEIE  1
`define BDIRQ_AUXIE   2
`define BDIRQ_SEL     3
`define BDIRQ_FIRST   6
`define BDIRQ_SECOND  7
`define BDIRQ_CHARM   13
`define BDIRQ_MODIE   14
`define BDIRQ_MODCHG  15
`define BDIRQ_ERRSUM  15
// ==========================================================
// Reset values and vector base
`define BDIRQ_VEC_BASE 9'h000
`define BDIRQ_JUMPER   1'b0
`endif

// File: verilog/bdirq_pkg.sv
// Types shared by the done sections and the request top.
// Assumes nothing beyond a single clock domain.
package bdirq_pkg;
  // Sequence-decoder requests for one direction
  typedef struct packed {
    logic setFirst;
    logic setSecond;
    logic clearRun;
  } bdirq_seq_t;

  // Four outputs of a done section
  typedef struct packed {
    logic clearRun;
    logic setFirst;
    logic setSecond;
    logic bufferSelect;
  } bdirq_done_t;

  // Bus request sequencer
  typedef enum logic [1:0] {BI_IDLE, BI_YIELD, BI_ACQUIRE, BI_MASTER} bdirq_bus_t;
endpackage : bdirq_pkg

// File: verilog/bdirq_done.sv
// One completion section: buffer select, done set pulses and run clear.
// Assumes strobe and advance pulses are single-cycle and never coincide.
module bdirq_done
  import bdirq_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset_n,
  // Counter path
  input  wire logic        countCheckStrobe,
  input  wire logic        countAdvancePulse,
  input  wire logic        countOverflow,
  // Sequence path
  input  wire bdirq_seq_t  seqReq,
  // Section outputs
  output bdirq_done_t      doneOut
);
  typedef struct packed {
    logic        wrapped;
    bdirq_done_t out;
  } bdirq_dstate_t;

  bdirq_dstate_t s_q;
  bdirq_dstate_t s_d;

  // ==========================================================
  // Next state
  always_comb begin
    s_d = s_q;
    s_d.out.setFirst  = seqReq.setFirst;
    s_d.out.setSecond = seqReq.setSecond;
    s_d.out.clearRun  = seqReq.clearRun;
    if (countCheckStrobe) begin
      s_d.out.bufferSelect = ~s_q.out.bufferSelect;
      s_d.wrapped          = s_q.out.bufferSelect;
    end
    if (countAdvancePulse) begin
      // Primary-only use never reports done; only a real switch does
      if (s_q.out.bufferSelect) s_d.out.setFirst = 1'b1;
      else if (s_q.wrapped) s_d.out.setSecond = 1'b1;
      if (countOverflow) s_d.out.clearRun = 1'b1;
    end
  end

  // Registered copy, so every output is a flop
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) s_q <= '0;
    else s_q <= s_d;
  end

  assign doneOut = s_q.out;

  sequence checkSeq;
    countCheckStrobe;
  endsequence

  AST_SEL_TOGGLE: assert property (@(posedge clk) disable iff (!reset_n)
    checkSeq |=> doneOut.bufferSelect != $past(doneOut.bufferSelect))
    else $error("select did not toggle");
  AST_FIRST_DONE: assert property (@(posedge clk) disable iff (!reset_n)
    countAdvancePulse && doneOut.bufferSelect |=> doneOut.setFirst)
    else $error("first done not set");
  AST_RUN_CLEAR: assert property (@(posedge clk) disable iff (!reset_n)
    countAdvancePulse && countOverflow |=> doneOut.clearRun)
    else $error("run not cleared");
  AST_NO_DONE: assert property (@(posedge clk) disable iff (!reset_n)
    countAdvancePulse && !doneOut.bufferSelect && !s_q.wrapped && !seqReq.setFirst
    |=> !doneOut.setFirst)
    else $error("done set while primary in use");
endmodule : bdirq_done

// File: verilog/bdirq_top.sv
// Done control and interrupt request/vector logic of a DMA line interface.
// Assumes a register port with read data one cycle after the strobe,
// bus handshake inputs already synchronous to clk.
`include "bdirq_defs.svh"
module bdirq_top
  import bdirq_pkg::*;
#(
  parameter logic [8:0] VECTOR_BASE = `BDIRQ_VEC_BASE,
  parameter logic       JUMPER_A    = `BDIRQ_JUMPER,
  parameter logic       JUMPER_B    = `BDIRQ_JUMPER
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset_n,
  // Register port
  input  wire logic [7:0]  regAddr,
  input  wire logic [15:0] regWdata,
  input  wire logic        regWr,
  input  wire logic        regRd,
  output logic      [15:0] regRdata,
  // Transmit count path
  input  wire logic        txCountCheckStrobe,
  input  wire logic        txCountAdvancePulse,
  input  wire bdirq_seq_t  txSeq,
  // Receive count path
  input  wire logic        rxCountCheckStrobe,
  input  wire logic        rxCountAdvancePulse,
  input  wire bdirq_seq_t  rxSeq,
  input  wire logic        countOverflow,
  // Buffer selects to the count/address addressing logic
  output logic             txBufferSelect,
  output logic             rxBufferSelect,
  // Event sources
  input  wire logic [7:0]  errorEvents,
  input  wire logic [2:0]  fixedCharMatch,
  input  wire logic        progCharMatch,
  input  wire logic        ringIndicator,
  input  wire logic        carrierDetect,
  input  wire logic        clearToSend,
  input  wire logic        userOptionA,
  input  wire logic        userOptionB,
  // Request lines
  output logic             txErrorIrqReq,
  output logic             rxMatchIrqReq,
  output logic             modemStatusIrqReq,
  // DMA bus master
  input  wire logic        dmaGrant,
  output logic             dmaRequest,
  output logic             dmaCycleStart,
  // Interrupt bus handshake
  input  wire logic        grantIn,
  input  wire logic        busBusy,
  input  wire logic        slaveAck,
  output logic             grantOut,
  output logic             busRequest,
  output logic             sysAck,
  output logic             busMaster,
  output logic             intrOut,
  output logic [8:0]       intrVector
);
  typedef struct packed {
    logic        txRun, txDoneIe, txErrIe, txModIe, txFirst, txSecond, modemChange;
    logic        rxRun, rxDoneIe, rxCharIe, rxFirst, rxSecond, charMatch;
    logic [7:0]  errFlags;
    logic        errSum;
    logic [2:0]  modemPrev;
    logic        dmaGrantPrev, grantPrev;
    logic        txReq, rxReq, dsReq;
    logic        dmaReq, dmaStart;
    bdirq_bus_t  bus;
    logic        grantOut, busRequest, sack, master, intr, vecBit2;
    logic        srvTx, srvRx;
    logic [8:0]  vector;
    logic [15:0] rdata;
  } bdirq_state_t;

  bdirq_state_t s_q;
  bdirq_state_t s_d;
  bdirq_done_t  txDone;
  bdirq_done_t  rxDone;

  // ==========================================================
  // Completion sections
  bdirq_done u_txDone (
    .clk               (clk),
    .reset_n           (reset_n),
    .countCheckStrobe  (txCountCheckStrobe),
    .countAdvancePulse (txCountAdvancePulse),
    .countOverflow     (countOverflow),
    .seqReq            (txSeq),
    .doneOut           (txDone)
  );

  bdirq_done u_rxDone (
    .clk               (clk),
    .reset_n           (reset_n),
    .countCheckStrobe  (rxCountCheckStrobe),
    .countAdvancePulse (rxCountAdvancePulse),
    .countOverflow     (countOverflow),
    .seqReq            (rxSeq),
    .doneOut           (rxDone)
  );

  // Write-one-to-clear mask for one flag: only a write to this offset counts
  function automatic logic w1c(input logic [7:0] off, input int bitPos);
    return regWr && regAddr == off && regWdata[bitPos];
  endfunction : w1c

  // ==========================================================
  // Next state
  logic [2:0] modemNow;
  logic       intrA;
  logic       intrB;
  logic       anyReq;

  always_comb begin
    s_d      = s_q;
    modemNow = {ringIndicator, carrierDetect, clearToSend};
    // Flags: clear by software first, so a set in the same cycle wins
    if (w1c(`BDIRQ_TXCSR, `BDIRQ_FIRST))  s_d.txFirst     = 1'b0;
    if (w1c(`BDIRQ_TXCSR, `BDIRQ_SECOND)) s_d.txSecond    = 1'b0;
    if (w1c(`BDIRQ_TXCSR, `BDIRQ_MODCHG)) s_d.modemChange = 1'b0;
    if (w1c(`BDIRQ_RXCSR, `BDIRQ_FIRST))  s_d.rxFirst     = 1'b0;
    if (w1c(`BDIRQ_RXCSR, `BDIRQ_SECOND)) s_d.rxSecond    = 1'b0;
    if (w1c(`BDIRQ_RXCSR, `BDIRQ_CHARM))  s_d.charMatch   = 1'b0;
    if (w1c(`BDIRQ_ERRCSR, `BDIRQ_ERRSUM)) s_d.errSum     = 1'b0;
    if (regWr && regAddr == `BDIRQ_ERRCSR) s_d.errFlags = s_q.errFlags & ~regWdata[7:0];
    // Control bits
    if (regWr && regAddr == `BDIRQ_TXCSR) begin
      s_d.txRun    = regWdata[`BDIRQ_RUN];
      s_d.txDoneIe = regWdata[`BDIRQ_DONEIE];
      s_d.txErrIe  = regWdata[`BDIRQ_AUXIE];
      s_d.txModIe  = regWdata[`BDIRQ_MODIE];
    end
    if (regWr && regAddr == `BDIRQ_RXCSR) begin
      s_d.rxRun    = regWdata[`BDIRQ_RUN];
      s_d.rxDoneIe = regWdata[`BDIRQ_DONEIE];
      s_d.rxCharIe = regWdata[`BDIRQ_AUXIE];
    end
    // Hardware stop beats a software start in the same cycle
    if (txDone.clearRun) s_d.txRun = 1'b0;
    if (rxDone.clearRun) s_d.rxRun = 1'b0;
    if (txDone.setFirst)  s_d.txFirst  = 1'b1;
    if (txDone.setSecond) s_d.txSecond = 1'b1;
    if (rxDone.setFirst)  s_d.rxFirst  = 1'b1;
    if (rxDone.setSecond) s_d.rxSecond = 1'b1;
    // Error flags and their summary
    s_d.errFlags = s_d.errFlags | errorEvents;
    if (|(errorEvents & ~s_q.errFlags)) s_d.errSum = 1'b1;
    if (|fixedCharMatch || progCharMatch) s_d.charMatch = 1'b1;
    s_d.modemPrev = modemNow;
    if (modemNow != s_q.modemPrev) s_d.modemChange = 1'b1;
    // Three request lines, registered
    s_d.txReq = (s_q.txDoneIe && (s_q.txFirst || s_q.txSecond))
              || (s_q.txErrIe && s_q.errSum);
    s_d.rxReq = (s_q.rxDoneIe && (s_q.rxFirst || s_q.rxSecond))
              || (s_q.rxCharIe && s_q.charMatch);
    s_d.dsReq = s_q.modemChange || (JUMPER_A && userOptionA)
              || (JUMPER_B && userOptionB);
    // DMA: one cycle per grant edge
    s_d.dmaGrantPrev = dmaGrant;
    s_d.dmaReq       = s_q.txRun || s_q.rxRun;
    s_d.dmaStart     = dmaGrant && !s_q.dmaGrantPrev && s_q.dmaReq;
    // Served latches fall once their source drops
    if (!s_q.rxReq) s_d.srvRx = 1'b0;
    if (!(s_q.txReq || s_q.dsReq)) s_d.srvTx = 1'b0;
    intrB  = s_q.rxReq && !s_q.srvRx;
    intrA  = (s_q.txReq || s_q.dsReq) && !s_q.srvTx;
    anyReq = intrA || intrB;
    // ==========================================================
    // Bus request sequencer
    s_d.grantPrev = grantIn;
    unique case (s_q.bus)
      BI_IDLE: begin
        s_d.busRequest = anyReq;
        s_d.grantOut   = grantIn && !anyReq;
        if (grantIn && !s_q.grantPrev && anyReq) begin
          s_d.grantOut = 1'b0;
          s_d.sack     = 1'b1;
          if (s_q.dmaReq) begin
            s_d.bus = BI_YIELD;
          end else begin
            s_d.busRequest = 1'b0;
            s_d.vecBit2    = !intrB;
            s_d.bus        = BI_ACQUIRE;
          end
        end
      end
      BI_YIELD: begin
        s_d.grantOut = 1'b0;
        if (!busBusy) begin
          s_d.sack = 1'b0;
          s_d.bus  = BI_IDLE;
        end
      end
      BI_ACQUIRE: begin
        s_d.grantOut = 1'b0;
        if (!busBusy) begin
          s_d.sack   = 1'b0;
          s_d.master = 1'b1;
          s_d.intr   = 1'b1;
          s_d.vector = VECTOR_BASE | {6'h00, s_q.vecBit2, 2'h0};
          s_d.bus    = BI_MASTER;
        end
      end
      BI_MASTER: begin
        s_d.grantOut = 1'b0;
        if (slaveAck) begin
          s_d.master = 1'b0;
          s_d.intr   = 1'b0;
          s_d.vector = 9'h000;
          if (s_q.vecBit2) s_d.srvTx = 1'b1;
          else s_d.srvRx = 1'b1;
          s_d.bus = BI_IDLE;
        end
      end
    endcase
    // Read data, one cycle after the strobe; unmapped reads give zero
    s_d.rdata = 16'h0000;
    if (regRd) begin
      unique case (regAddr)
        `BDIRQ_TXCSR: begin
          s_d.rdata[`BDIRQ_RUN]    = s_q.txRun;
          s_d.rdata[`BDIRQ_DONEIE] = s_q.txDoneIe;
          s_d.rdata[`BDIRQ_AUXIE]  = s_q.txErrIe;
          s_d.rdata[`BDIRQ_SEL]    = txDone.bufferSelect;
          s_d.rdata[`BDIRQ_FIRST]  = s_q.txFirst;
          s_d.rdata[`BDIRQ_SECOND] = s_q.txSecond;
          s_d.rdata[`BDIRQ_MODIE]  = s_q.txModIe;
          s_d.rdata[`BDIRQ_MODCHG] = s_q.modemChange;
        end
        `BDIRQ_RXCSR: begin
          s_d.rdata[`BDIRQ_RUN]    = s_q.rxRun;
          s_d.rdata[`BDIRQ_DONEIE] = s_q.rxDoneIe;
          s_d.rdata[`BDIRQ_AUXIE]  = s_q.rxCharIe;
          s_d.rdata[`BDIRQ_SEL]    = rxDone.bufferSelect;
          s_d.rdata[`BDIRQ_FIRST]  = s_q.rxFirst;
          s_d.rdata[`BDIRQ_SECOND] = s_q.rxSecond;
          s_d.rdata[`BDIRQ_CHARM]  = s_q.charMatch;
        end
        `BDIRQ_ERRCSR: begin
          s_d.rdata[7:0]           = s_q.errFlags;
          s_d.rdata[`BDIRQ_ERRSUM] = s_q.errSum;
        end
        default: s_d.rdata = 16'h0000;
      endcase
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) s_q <= '0;
    else s_q <= s_d;
  end

  // Outputs straight from flops
  assign regRdata          = s_q.rdata;
  assign txBufferSelect    = txDone.bufferSelect;
  assign rxBufferSelect    = rxDone.bufferSelect;
  assign txErrorIrqReq     = s_q.txReq;
  assign rxMatchIrqReq     = s_q.rxReq;
  assign modemStatusIrqReq = s_q.dsReq;
  assign dmaRequest        = s_q.dmaReq;
  assign dmaCycleStart     = s_q.dmaStart;
  assign grantOut          = s_q.grantOut;
  assign busRequest        = s_q.busRequest;
  assign sysAck            = s_q.sack;
  assign busMaster         = s_q.master;
  assign intrOut           = s_q.intr;
  assign intrVector        = s_q.vector;

  // ==========================================================
  // Checks
  sequence yieldEntry;
    s_q.bus == BI_IDLE && grantIn && !s_q.grantPrev && anyReq && s_q.dmaReq;
  endsequence

  // Bus released while acquiring: this block becomes master next
  sequence masterEntry;
    s_q.bus == BI_ACQUIRE && !busBusy;
  endsequence

  AST_TX_REQ: assert property (@(posedge clk) disable iff (!reset_n)
    s_q.txDoneIe && s_q.txFirst |=> txErrorIrqReq)
    else $error("tx request missing");
  AST_RX_REQ: assert property (@(posedge clk) disable iff (!reset_n)
    s_q.rxDoneIe && s_q.rxSecond |=> rxMatchIrqReq)
    else $error("rx request missing");
  AST_MODEM: assert property (@(posedge clk) disable iff (!reset_n)
    $changed(carrierDetect) ##1 1'b1 |=> s_q.modemChange ##1 modemStatusIrqReq)
    else $error("modem change not flagged");
  AST_ERRSUM: assert property (@(posedge clk) disable iff (!reset_n)
    |(errorEvents & ~s_q.errFlags) |=> s_q.errSum)
    else $error("error summary not set");
  AST_DMA_ONE: assert property (@(posedge clk) disable iff (!reset_n)
    dmaCycleStart |=> !dmaCycleStart)
    else $error("two cycles for one grant");
  AST_YIELD: assert property (@(posedge clk) disable iff (!reset_n)
    yieldEntry |=> sysAck && !grantOut && busRequest)
    else $error("grant not blocked for DMA");
  AST_RELEASE: assert property (@(posedge clk) disable iff (!reset_n)
    s_q.bus == BI_YIELD && !busBusy |=> !sysAck && busRequest)
    else $error("yield release wrong");
  AST_VECTOR: assert property (@(posedge clk) disable iff (!reset_n)
    $rose(intrOut) |-> intrVector[2] == s_q.vecBit2)
    else $error("vector bit 2 wrong");
  AST_SERVED: assert property (@(posedge clk) disable iff (!reset_n)
    s_q.srvRx && s_q.rxReq && !s_q.txReq && !s_q.dsReq && s_q.bus == BI_IDLE
    |=> !busRequest)
    else $error("served source re-requested");
  AST_TX_SECOND: assert property (@(posedge clk) disable iff (!reset_n)
    s_q.txDoneIe && s_q.txSecond |=> txErrorIrqReq)
    else $error("tx second done request missing");
  AST_ERR_REQ: assert property (@(posedge clk) disable iff (!reset_n)
    s_q.txErrIe && s_q.errSum |=> txErrorIrqReq)
    else $error("error request missing");
  AST_CHAR_REQ: assert property (@(posedge clk) disable iff (!reset_n)
    s_q.rxCharIe && s_q.charMatch |=> rxMatchIrqReq)
    else $error("match request missing");
  AST_CHAR_SET: assert property (@(posedge clk) disable iff (!reset_n)
    |fixedCharMatch || progCharMatch |=> s_q.charMatch)
    else $error("match flag not set");
  AST_JUMPER: assert property (@(posedge clk) disable iff (!reset_n)
    JUMPER_A && userOptionA |=> modemStatusIrqReq)
    else $error("user option request missing");
  AST_RUN_STOP: assert property (@(posedge clk) disable iff (!reset_n)
    txDone.clearRun |=> !s_q.txRun)
    else $error("tx run not stopped");
  AST_DMA_REQ: assert property (@(posedge clk) disable iff (!reset_n)
    s_q.txRun |=> dmaRequest)
    else $error("dma request missing while running");
  AST_DMA_START: assert property (@(posedge clk) disable iff (!reset_n)
    dmaGrant && !$past(dmaGrant) && dmaRequest |=> dmaCycleStart)
    else $error("no bus cycle for grant");
  AST_MASTER: assert property (@(posedge clk) disable iff (!reset_n)
    masterEntry |=> busMaster && intrOut && !sysAck)
    else $error("mastership not taken");
  AST_INTR_DROP: assert property (@(posedge clk) disable iff (!reset_n)
    s_q.bus == BI_MASTER && slaveAck
    |=> !intrOut && !busMaster && intrVector == 9'h000)
    else $error("vector not withdrawn");
endmodule : bdirq_top

// File: tb/bdirq_host.sv
// Host bus model: grants interrupt requests, hands out DMA grants, takes vectors.
// Assumes the block drops its request when it acknowledges a grant to take the bus, not when it yields to DMA.
module bdirq_host (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       reset_n,
  // From the block
  input  wire logic       busRequest,
  input  wire logic       sysAck,
  input  wire logic       intrOut,
  input  wire logic       dmaRequest,
  // Pacing chosen by the bench
  input  wire logic [3:0] grantDelay,
  // To the block
  output logic            grantIn,
  output logic            busBusy,
  output logic            slaveAck,
  output logic            dmaGrant
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] waitQ;
  // ==========================================================
  // Arbitration: another master still holds the bus when a grant goes out,
  // so busy falls after the acknowledge, or when a grant passes through untaken, as on a loaded bus
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      grantIn  <= 1'b0;
      busBusy  <= 1'b0;
      slaveAck <= 1'b0;
      dmaGrant <= 1'b0;
      waitQ    <= 4'h0;
    end else begin
      dmaGrant <= dmaRequest & ~dmaGrant; // Single-cycle grants
      slaveAck <= intrOut & ~slaveAck;    // Vector taken one cycle after it shows
      if (sysAck) begin
        grantIn <= 1'b0;
        busBusy <= 1'b0;
      end else if (grantIn && !busRequest) begin
        // Grant passed through untaken: withdraw it so a later request sees a fresh edge
        grantIn <= 1'b0;
        busBusy <= 1'b0;
      end else if (busRequest && !grantIn) begin
        // Grant is issued again while the request stays up
        if (waitQ == grantDelay) begin
          grantIn <= 1'b1;
          busBusy <= 1'b1;
          waitQ   <= 4'h0;
        end else begin
          waitQ <= waitQ + 4'h1;
        end
      end
    end
  end
endmodule : bdirq_host

// File: tb/testbench.sv
// Self-checking bench for the done/request block, register model kept in integers.
// Assumes the host model answers every interrupt and DMA request on its own.
`include "bdirq_defs.svh"
module testbench
  import bdirq_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [8:0] VB = 9'h0a0;
  localparam logic [7:0] OFS [4] = '{`BDIRQ_TXCSR, `BDIRQ_RXCSR, `BDIRQ_ERRCSR, 8'h0c};
  logic             clk, reset_n, regWr, regRd, countOverflow, progCharMatch;
  logic             userOptionA, userOptionB, txSel, rxSel, txIrq, rxIrq, msIrq;
  logic             dmaGrant, dmaRequest, dmaCycleStart, grantIn, busBusy, slaveAck;
  logic             grantOut, busRequest, sysAck, busMaster, intrOut;
  logic [3:0]       cnt, grantDelay;
  logic [7:0]       regAddr, errorEvents, m;
  logic [15:0]      regWdata, regRdata;
  logic [2:0]       fixedCharMatch, modemLines;
  logic [8:0]       intrVector;
  bdirq_seq_t       txSeq, rxSeq;
  int               nFail = 0, totalChecks = 0, cycles = 0, grants = 0, starts = 0, hits;
  int               csrM [4] = '{0, 0, 0, 0}; // Expected register contents
  bdirq_top #(.VECTOR_BASE(VB), .JUMPER_A(1'b1), .JUMPER_B(1'b0)) u_dut (
    .clk(clk), .reset_n(reset_n), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
    .regRd(regRd), .regRdata(regRdata), .txCountCheckStrobe(cnt[0]),
    .txCountAdvancePulse(cnt[2]), .txSeq(txSeq), .rxCountCheckStrobe(cnt[1]),
    .rxCountAdvancePulse(cnt[3]), .rxSeq(rxSeq), .countOverflow(countOverflow),
    .txBufferSelect(txSel), .rxBufferSelect(rxSel), .errorEvents(errorEvents),
    .fixedCharMatch(fixedCharMatch), .progCharMatch(progCharMatch),
    .ringIndicator(modemLines[2]), .carrierDetect(modemLines[1]),
    .clearToSend(modemLines[0]), .userOptionA(userOptionA), .userOptionB(userOptionB),
    .txErrorIrqReq(txIrq), .rxMatchIrqReq(rxIrq), .modemStatusIrqReq(msIrq),
    .dmaGrant(dmaGrant), .dmaRequest(dmaRequest), .dmaCycleStart(dmaCycleStart),
    .grantIn(grantIn), .busBusy(busBusy), .slaveAck(slaveAck), .grantOut(grantOut),
    .busRequest(busRequest), .sysAck(sysAck), .busMaster(busMaster), .intrOut(intrOut),
    .intrVector(intrVector));
  bdirq_host u_host (
    .clk(clk), .reset_n(reset_n), .busRequest(busRequest), .sysAck(sysAck),
    .intrOut(intrOut), .dmaRequest(dmaRequest), .grantDelay(grantDelay),
    .grantIn(grantIn), .busBusy(busBusy), .slaveAck(slaveAck), .dmaGrant(dmaGrant));
  // ==========================================================
  // Clock, and a cycle ceiling well above the few hundred cycles the tests take
  initial clk = 1'b0;
  always #25 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (dmaGrant === 1'b1) grants++;
    if (dmaCycleStart === 1'b1) starts++;
    if (cycles == 20000) begin
      nFail++;
      finalReport();
    end
  end
  // ==========================================================
  // Shared tasks
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    totalChecks++;
    if (seen !== exp) begin
      nFail++;
      $display("unexpected at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  task automatic wr(input int r, input logic [15:0] d);
    @(posedge clk);
    regWr    <= 1'b1;
    regAddr  <= OFS[r];
    regWdata <= d;
    @(posedge clk);
    regWr    <= 1'b0;
  endtask : wr
  // Read data stand only in the cycle after the strobe
  task automatic rdChk(input int r);
    @(posedge clk);
    regRd   <= 1'b1;
    regAddr <= OFS[r];
    @(posedge clk);
    regRd   <= 1'b0;
    #1;
    chk(regRdata, 16'(csrM[r]));
  endtask : rdChk
  // One-cycle count pulse: 0/1 check strobe tx/rx, 2/3 advance tx/rx
  task automatic evt(input int k, input logic ovf);
    @(posedge clk);
    countOverflow <= ovf;
    cnt[k]        <= 1'b1;
    @(posedge clk);
    cnt           <= 4'h0;
    cyc(1);
  endtask : evt
  task automatic waitHigh(input logic which);
    int n;
    n = 0;
    while ((which ? intrOut : sysAck) !== 1'b1 && n < 200) begin
      cyc(1);
      n++;
    end
  endtask : waitHigh
  task automatic finalReport();
    $display("checks %0d mismatches %0d", totalChecks, nFail);
    if (nFail == 0 && totalChecks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : finalReport
  // ==========================================================
  // Main sequence
  initial begin
    void'($urandom(32'h9925df32));
    {reset_n, regWr, regRd, countOverflow, progCharMatch, userOptionA, userOptionB} = '0;
    {cnt, grantDelay, regAddr, errorEvents, regWdata, fixedCharMatch, modemLines} = '0;
    {txSeq, rxSeq} = '0;
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    cyc(1);
    chk({txSel, rxSel, txIrq, rxIrq, msIrq, intrOut, dmaRequest}, 16'h0);
    for (int r = 0; r < 4; r++) rdChk(r);
    $display("test reset done");
    wr(0, 16'h0001);
    csrM[0] = 16'h0001;
    evt(2, 1'b0);
    rdChk(0);
    chk(dmaRequest, 1'b1);
    wr(0, 16'h0000);
    csrM[0] = 0;
    $display("test no done while first buffer in use done");
    // Chain both buffers per direction, the second one empty
    for (int d = 0; d < 2; d++) begin
      grantDelay <= 4'($urandom % 8);
      wr(d, 16'h0003);
      evt(d, 1'b0);
      chk(d ? rxSel : txSel, 1'b1);
      evt(2 + d, 1'b0);
      csrM[d] = 16'h004b;
      rdChk(d);
      chk(d ? rxIrq : txIrq, 1'b1);
      waitHigh(1'b0);
      chk({intrOut, grantOut, busRequest, dmaRequest}, 16'h3);
      while (sysAck === 1'b1) cyc(1);
      chk(busRequest, 1'b1);
      evt(d, 1'b1);
      chk(d ? rxSel : txSel, 1'b0);
      evt(2 + d, 1'b1);
      waitHigh(1'b1);
      chk({busMaster, intrVector}, {1'b1, VB | (d ? 9'h000 : 9'h004)});
      cyc(3);
      hits = 0;
      repeat (40) begin
        cyc(1);
        if (intrOut === 1'b1) hits++;
      end
      chk(16'(hits), 16'h0);
      csrM[d] = 16'h00c2;
      rdChk(d);
      wr(d, 16'h00c0);
      csrM[d] = 0;
      rdChk(d);
    end
    $display("test buffer chaining done");
    m = 8'($urandom) | 8'h01;
    wr(0, 16'h0004);
    @(posedge clk);
    errorEvents <= m;
    @(posedge clk);
    errorEvents <= 8'h00;
    cyc(4);
    csrM[2] = {8'h80, m};
    rdChk(2);
    chk(txIrq, 1'b1);
    wr(2, 16'h80ff);
    wr(0, 16'h0000);
    csrM[2] = 0;
    rdChk(2);
    $display("test error summary done");
    for (int i = 0; i < 4; i++) begin
      wr(1, 16'h0004);
      @(posedge clk);
      if (i < 3) fixedCharMatch <= 3'(1 << i);
      else progCharMatch <= 1'b1;
      @(posedge clk);
      {fixedCharMatch, progCharMatch} <= 4'h0;
      cyc(4);
      csrM[1] = 16'h2004;
      rdChk(1);
      chk(rxIrq, 1'b1);
      wr(1, 16'h2000);
      csrM[1] = 0;
    end
    $display("test character match done");
    // Each modem line turns on, then off
    for (int i = 0; i < 6; i++) begin
      @(posedge clk);
      modemLines[i % 3] <= ~modemLines[i % 3];
      cyc(4);
      csrM[0] = 16'h8000;
      rdChk(0);
      chk(msIrq, 1'b1);
      wr(0, 16'h8000);
      csrM[0] = 0;
      cyc(4);
      chk(msIrq, 1'b0);
    end
    @(posedge clk);
    userOptionB <= 1'b1;
    cyc(4);
    chk(msIrq, 1'b0);
    @(posedge clk);
    userOptionB <= 1'b0;
    userOptionA <= 1'b1;
    cyc(4);
    chk(msIrq, 1'b1);
    userOptionA <= 1'b0;
    $display("test modem status done");
    for (int d = 0; d < 2; d++) begin
      wr(d, 16'h0001);
      @(posedge clk);
      if (d == 1) rxSeq <= 3'b011;
      else txSeq <= 3'b101;
      @(posedge clk);
      {txSeq, rxSeq} <= '0;
      cyc(4);
      csrM[d] = d ? 16'h0080 : 16'h0040;
      rdChk(d);
      wr(d, 16'h00c0);
      csrM[d] = 0;
    end
    $display("test sequence path done");
    chk(16'(starts > 0 && starts <= grants), 16'h1);
    $display("test bus cycles per grant done");
    finalReport();
  end
endmodule : testbench
